// *** common/ddrpc_pkg.sv ***
// How it works
// - in power-down only clock, termination control and clock enable receivers stay on
// - in self refresh only the clock enable receiver stays on
// - a command sampled with chip select high is ignored
// - commands decode from chip select, row strobe, column strobe and write enable together
// - termination control high switches termination on when the extended register enables it
// - termination covers data, strobes, read strobe and masks; x16 covers both bytes
// - with termination disabled in the extended register, termination control is ignored
// - a write beat sampled with its mask high leaves the stored byte unchanged
// - the mask is sampled once per data beat, on both strobe edges
// - on x8 the mask pin is write mask or read strobe, per extended register
// - activate, read, write and single precharge go to the bank on bank_select
// - in a mode set cycle bank_select picks mode or extended mode register
// - row address on activate; column and auto precharge on read and write
// - precharge with precharge_all_flag low closes one bank, high closes all
// - a single-bank precharge targets the bank on bank_select
// - mode set commands take the opcode from address_inputs
// - address and command inputs are sampled on the rising clock crossing
// - clock enable low gives precharge power-down or self refresh if idle, else active power-down
// - clock enable is synchronous except for self refresh exit; the code takes that exit from the clocked cke_r too
package ddrpc_pkg;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_COL_W = 5;
  localparam int MEM_AW = BANK_W + MEM_COL_W;
  localparam int NUM_MODE_REGS = 4;
  localparam int AP_BIT = 10;
  localparam int EMR_RTT_LO_BIT = 2;
  localparam int EMR_RTT_HI_BIT = 6;
  localparam int EMR_READ_ONLY_STROBE_BIT = 11;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BL_W = 3;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BL_BEATS_4 = 4'h4;
  localparam logic [3:0] BL_BEATS_8 = 4'h8;
  localparam logic [1:0] SEL_MR = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0002;
  localparam logic [ADDR_W-1:0] EMR_RESET = 14'h0000;

  // codes are the {row, column, write} strobe levels with chip select low
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } ddrpc_cmd_e;

  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_PD_PRE = 2'b01,
    PWR_SREF = 2'b11,
    PWR_PD_ACT = 2'b10
  } ddrpc_pwr_e;

  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic termination_control;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] address_inputs;
  } ddrpc_pins_s;

  typedef struct packed {
    logic valid;
    logic mask;
    logic [DATA_W-1:0] data;
  } ddrpc_beat_pin_s;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic mask;
    logic [DATA_W-1:0] data;
  } ddrpc_beat_s;

  typedef struct packed {
    logic valid;
    ddrpc_cmd_e kind;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic pre_all;
  } ddrpc_cmd_s;

  localparam int BEAT_W = $bits(ddrpc_beat_s);
endpackage : ddrpc_pkg

// *** verif/ddrpc_ctrl_model.sv ***
`timescale 1ns/1ps
module ddrpc_ctrl_model (
  input wire logic ref_clk,
  output logic clock_enable,
  output ddrpc_pkg::ddrpc_pins_s cmd_pins,
  output ddrpc_pkg::ddrpc_beat_pin_s beat_pins
);
  import ddrpc_pkg::*;
  logic odt_r;
  initial
  begin
    odt_r = 1'b0;
    clock_enable = 1'b0;
    cmd_pins = '1;
    beat_pins = '0;
  end
  // the bench issues reads and writes with cke high, except one read that it sends with cke low
  task automatic issue(input logic cs_n, input logic cke, input ddrpc_cmd_e kind,
                       input logic [2:0] bank, input logic [13:0] addr);
    @(negedge ref_clk);
    clock_enable = cke;
    cmd_pins = {cs_n, kind, odt_r, bank, addr};
    @(negedge ref_clk);
    // idle lines flip so a stale command never looks freshly driven
    cmd_pins = ~cmd_pins;
    cmd_pins.chip_select_n = 1'b1;
    cmd_pins.termination_control = odt_r;
  endtask : issue
  task automatic set_cke(input logic v);
    @(negedge ref_clk);
    clock_enable = v;
  endtask : set_cke
  task automatic set_odt(input logic v);
    @(negedge ref_clk);
    odt_r = v;
    cmd_pins.termination_control = v;
  endtask : set_odt
  task automatic burst(input logic [3:0] mask, input logic [31:0] data);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      beat_pins = {1'b1, mask[i], data[8*i+:8]};
    end
    @(negedge ref_clk);
    beat_pins = {1'b0, 1'b0, ~beat_pins.data};
  endtask : burst
endmodule : ddrpc_ctrl_model

// *** verif/ddrpc_top_properties.sv ***
`timescale 1ns/1ps
module ddrpc_top_properties (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire ddrpc_pkg::ddrpc_pins_s cmd_pins,
  input wire ddrpc_pkg::ddrpc_cmd_s cmd_out,
  input wire ddrpc_pkg::ddrpc_pwr_e power_state,
  input wire logic [ddrpc_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic rx_cmd_enable,
  input wire logic rx_clk_term_enable,
  input wire logic term_data_enable,
  input wire logic [ddrpc_pkg::ADDR_W-1:0] ext_mode_reg
);
  import ddrpc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // pins seen at edge n come out as a decoded command three samples later
  property p_cs_mask;
    cmd_out.valid |-> !$past(cmd_pins.chip_select_n, 3);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("deselected command taken");
  property p_decode;
    cmd_out.valid |-> cmd_out.kind == {$past(cmd_pins.row_strobe_n, 3),
      $past(cmd_pins.col_strobe_n, 3), $past(cmd_pins.write_enable_n, 3)};
  endproperty
  a_decode: assert property (p_decode) else $error("command code mismatch");
  property p_bank;
    cmd_out.valid && cmd_out.kind inside {CMD_ACT, CMD_RD, CMD_WR}
      |-> cmd_out.bank == $past(cmd_pins.bank_select, 3);
  endproperty
  a_bank: assert property (p_bank) else $error("wrong bank");
  property p_row;
    cmd_out.valid && cmd_out.kind == CMD_ACT |-> cmd_out.row == $past(cmd_pins.address_inputs, 3);
  endproperty
  a_row: assert property (p_row) else $error("wrong row");
  property p_pre_close;
    cmd_out.valid && cmd_out.kind == CMD_PRE && cmd_out.pre_all |-> bank_open == '0;
  endproperty
  a_pre_close: assert property (p_pre_close) else $error("bank left open");
  property p_sref;
    power_state == PWR_SREF |-> !rx_clk_term_enable && !rx_cmd_enable;
  endproperty
  a_sref: assert property (p_sref) else $error("receiver on in self refresh");
  property p_pd;
    power_state inside {PWR_PD_PRE, PWR_PD_ACT} |-> rx_clk_term_enable && !rx_cmd_enable;
  endproperty
  a_pd: assert property (p_pd) else $error("receivers wrong in power-down");
  property p_term;
    term_data_enable |-> $past(cmd_pins.termination_control, 3)
      && ($past(ext_mode_reg[EMR_RTT_LO_BIT]) || $past(ext_mode_reg[EMR_RTT_HI_BIT]));
  endproperty
  a_term: assert property (p_term) else $error("termination without cause");
endmodule : ddrpc_top_properties

bind ddrpc_top ddrpc_top_properties u_props (.ref_clk(ref_clk), .resetn(resetn),
  .cmd_pins(cmd_pins), .cmd_out(cmd_out), .power_state(power_state), .bank_open(bank_open),
  .rx_cmd_enable(rx_cmd_enable), .rx_clk_term_enable(rx_clk_term_enable),
  .term_data_enable(term_data_enable), .ext_mode_reg(ext_mode_reg));

// *** verif/ddrpc_top_tb.sv ***
`timescale 1ns/1ps
module ddrpc_top_tb;
  import ddrpc_pkg::*;
  logic ref_clk, resetn, org_x16, org_x8, clock_enable, beat_ready, rx_cmd_enable;
  logic rx_clk_term_enable, term_data_enable, term_upper_enable, term_mask_enable;
  logic mask_pin_is_read_strobe, write_active, read_valid, access_cke_low;
  ddrpc_pins_s cmd_pins;
  ddrpc_beat_pin_s beat_pins;
  ddrpc_cmd_s cmd_out;
  ddrpc_pwr_e power_state;
  logic [NUM_BANKS-1:0] bank_open, exp_open;
  logic [ADDR_W-1:0] mode_reg, ext_mode_reg, op;
  logic [DATA_W-1:0] read_data;
  logic [31:0] seed, d0, d1;
  logic [2:0] b0;
  logic [4:0] c0;
  int fail_count, n_checks, n;

  ddrpc_ctrl_model m (.ref_clk(ref_clk), .clock_enable(clock_enable), .cmd_pins(cmd_pins),
    .beat_pins(beat_pins));
  ddrpc_top dut (.ref_clk(ref_clk), .resetn(resetn), .org_x16(org_x16), .org_x8(org_x8),
    .clock_enable(clock_enable), .cmd_pins(cmd_pins), .beat_pins(beat_pins),
    .beat_ready(beat_ready), .cmd_out(cmd_out), .power_state(power_state),
    .bank_open(bank_open), .rx_cmd_enable(rx_cmd_enable),
    .rx_clk_term_enable(rx_clk_term_enable), .term_data_enable(term_data_enable),
    .term_upper_enable(term_upper_enable), .term_mask_enable(term_mask_enable),
    .mask_pin_is_read_strobe(mask_pin_is_read_strobe), .mode_reg(mode_reg),
    .ext_mode_reg(ext_mode_reg), .write_active(write_active), .read_valid(read_valid),
    .read_data(read_data), .access_cke_low(access_cke_low));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cmd(input logic cs_n, input ddrpc_cmd_e k, input logic [2:0] b,
                     input logic [13:0] a);
    m.issue(cs_n, 1'b1, k, b, a);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("valid", cmd_out.valid, !cs_n);
    if (!cs_n)
      chk("kind", cmd_out.kind, k);
  endtask : cmd
  task automatic cke_to(input logic v, input ddrpc_pwr_e st);
    m.set_cke(v);
    repeat (4) @(negedge ref_clk);
    chk("pwr", power_state, st);
  endtask : cke_to
  task automatic wr(input logic [3:0] mask, input logic [31:0] d);
    m.issue(1'b0, 1'b1, CMD_WR, b0, {9'h0, c0});
    chk("beat_ready", beat_ready, 1'b1);
    m.burst(mask, d);
    for (n = 0; n < 40 && write_active !== 1'b0; n++)
      @(negedge ref_clk);
    if (n == 40)
    begin
      fail_count++;
      end_sim();
    end
    repeat (4) @(negedge ref_clk);
  endtask : wr

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100us;
    fail_count++;
    end_sim();
  end
  initial
  begin
    {seed, fail_count, n_checks, exp_open} = {32'hc878, 64'h0, 8'h0};
    {resetn, org_x16, org_x8} = 3'b001;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    chk("mr", mode_reg, MR_RESET);
    chk("rx_cmd", rx_cmd_enable, 1'b0);
    cke_to(1'b1, PWR_ON);
    $display("test power_up done");
    op = 14'(rnd());
    op[2:0] = BL_CODE_4;
    cmd(1'b0, CMD_MRS, {1'b0, SEL_MR}, op);
    chk("mr", mode_reg, op);
    op = 14'(rnd()) | 14'h0804;
    cmd(1'b0, CMD_MRS, {1'b0, SEL_EMR1}, op);
    chk("emr", ext_mode_reg, op);
    chk("mr_kept", mode_reg[2:0], BL_CODE_4);
    m.set_odt(1'b1);
    repeat (5) @(negedge ref_clk);
    chk("read_only_strobe", mask_pin_is_read_strobe, 1'b1);
    chk("term", term_data_enable, 1'b1);
    chk("term_dm", term_mask_enable, 1'b1);
    chk("term_up", term_upper_enable, 1'b0);
    {org_x16, org_x8} = 2'b10;
    repeat (3) @(negedge ref_clk);
    chk("term_up", term_upper_enable, 1'b1);
    chk("read_only_strobe", mask_pin_is_read_strobe, 1'b0);
    // odt stays high while the enable bits are cleared
    cmd(1'b0, CMD_MRS, {1'b0, SEL_EMR1}, op & 14'h37bb);
    repeat (3) @(negedge ref_clk);
    chk("term", term_data_enable, 1'b0);
    m.set_odt(1'b0);
    $display("test mode_odt done");
    for (int i = 0; i < 3; i++)
    begin
      b0 = 3'(rnd());
      op = 14'(rnd());
      cmd(1'b0, CMD_ACT, b0, op);
      exp_open[b0] = 1'b1;
      chk("bank", cmd_out.bank, b0);
      chk("row", cmd_out.row, op);
      chk("open", bank_open, exp_open);
    end
    cmd(1'b1, CMD_ACT, ~b0, op);
    chk("open", bank_open, exp_open);
    $display("test activate done");
    c0 = 5'(rnd()) & 5'h1c;
    d0 = rnd();
    d1 = rnd();
    wr(4'h0, d0);
    wr(4'h5, d1);
    for (int i = 0; i < 4; i++)
    begin
      cmd(1'b0, CMD_RD, b0, {9'h0, c0 + 5'(i)});
      chk("col", cmd_out.col, {5'h0, c0 + 5'(i)});
      chk("rd_valid", read_valid, 1'b1);
      chk("rd_data", read_data, i[0] ? d1[8*i+:8] : d0[8*i+:8]);
    end
    cmd(1'b0, CMD_RD, b0, 14'h0400);
    exp_open[b0] = 1'b0;
    chk("ap", cmd_out.auto_pre, 1'b1);
    chk("open", bank_open, exp_open);
    $display("test write_mask done");
    cmd(1'b0, CMD_ACT, b0, 14'(rnd()));
    exp_open[b0] = 1'b1;
    cmd(1'b0, CMD_PRE, b0, 14'h0000);
    exp_open[b0] = 1'b0;
    chk("pre_all", cmd_out.pre_all, 1'b0);
    chk("open", bank_open, exp_open);
    cmd(1'b0, CMD_ACT, b0, 14'(rnd()));
    exp_open[b0] = 1'b1;
    cke_to(1'b0, PWR_PD_ACT);
    chk("rx_ck", rx_clk_term_enable, 1'b1);
    m.issue(1'b0, 1'b0, CMD_ACT, b0 + 3'h1, 14'h0);
    repeat (4) @(negedge ref_clk);
    chk("open", bank_open, exp_open);
    cke_to(1'b1, PWR_ON);
    cmd(1'b0, CMD_PRE, 3'h0, 14'h0400);
    chk("pre_all", cmd_out.pre_all, 1'b1);
    chk("open", bank_open, 8'h00);
    cke_to(1'b0, PWR_PD_PRE);
    cke_to(1'b1, PWR_ON);
    // a read offered with clock enable low is flagged and not performed
    m.issue(1'b0, 1'b0, CMD_RD, b0, 14'h0);
    repeat (2) @(negedge ref_clk);
    chk("cke_low", access_cke_low, 1'b1);
    chk("rd_valid", read_valid, 1'b0);
    cke_to(1'b0, PWR_PD_PRE);
    cke_to(1'b1, PWR_ON);
    m.issue(1'b0, 1'b0, CMD_REF, 3'h0, 14'h0);
    repeat (4) @(negedge ref_clk);
    chk("pwr", power_state, PWR_SREF);
    chk("rx_ck", rx_clk_term_enable, 1'b0);
    cke_to(1'b1, PWR_ON);
    $display("test power done");
    end_sim();
  end
endmodule : ddrpc_top_tb

// *** verilog/ddrpc_fifo.sv ***
`timescale 1ns/1ps
module ddrpc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = store_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
      store_r[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : ddrpc_fifo

// *** verilog/ddrpc_mem.sv ***
`timescale 1ns/1ps
module ddrpc_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] cell_r [2**AW];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      cell_r[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= cell_r[rd_addr];
  end
endmodule : ddrpc_mem

// *** verilog/ddrpc_top.sv ***
`timescale 1ns/1ps
module ddrpc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic org_x16,
  input wire logic org_x8,
  input wire logic clock_enable,
  input wire ddrpc_pkg::ddrpc_pins_s cmd_pins,
  input wire ddrpc_pkg::ddrpc_beat_pin_s beat_pins,
  output logic beat_ready,
  output ddrpc_pkg::ddrpc_cmd_s cmd_out,
  output ddrpc_pkg::ddrpc_pwr_e power_state,
  output logic [ddrpc_pkg::NUM_BANKS-1:0] bank_open,
  output logic rx_cmd_enable,
  output logic rx_clk_term_enable,
  output logic term_data_enable,
  output logic term_upper_enable,
  output logic term_mask_enable,
  output logic mask_pin_is_read_strobe,
  output logic [ddrpc_pkg::ADDR_W-1:0] mode_reg,
  output logic [ddrpc_pkg::ADDR_W-1:0] ext_mode_reg,
  output logic write_active,
  output logic read_valid,
  output logic [ddrpc_pkg::DATA_W-1:0] read_data,
  output logic access_cke_low
);
  import ddrpc_pkg::*;

  function automatic logic [3:0] burst_beats(input logic [ADDR_W-1:0] mr);
    logic [MR_BL_W-1:0] code;
    code = mr[MR_BL_LSB +: MR_BL_W];
    if (code == BL_CODE_8)
      burst_beats = BL_BEATS_8;
    else
      burst_beats = BL_BEATS_4;
  endfunction : burst_beats

  function automatic logic [MEM_AW-1:0] mem_addr(input logic [BANK_W-1:0] bank,
                                                input logic [COL_W-1:0] col);
    mem_addr = {bank, col[MEM_COL_W-1:0]};
  endfunction : mem_addr

  ddrpc_pins_s pins_s1_r;
  ddrpc_pins_s pins_r;
  ddrpc_beat_pin_s beat_s1_r;
  ddrpc_beat_pin_s beat_r;
  logic cke_s1_r;
  logic cke_r;

  ddrpc_pwr_e pwr_r;
  ddrpc_pwr_e pwr_nxt;
  logic [ADDR_W-1:0] mode_regs_r [NUM_MODE_REGS];
  logic [NUM_BANKS-1:0] open_r;
  ddrpc_cmd_s cmd_r;
  ddrpc_cmd_e kind;
  logic cmd_live;
  logic cmd_accept;

  logic wr_act_r;
  logic [BANK_W-1:0] wr_bank_r;
  logic [COL_W-1:0] wr_col_r;
  logic [3:0] beats_left_r;
  logic rd_pend_r;

  logic term_allowed;
  logic term_on;
  logic read_only_strobe_sel;

  ddrpc_beat_s fifo_in;
  ddrpc_beat_s fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic rd_fire;

  // two-flop capture of every pin; the first stage feeds only the second
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pins_s1_r <= '{chip_select_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                     write_enable_n: 1'b1, default: '0};
      pins_r <= '{chip_select_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
                  write_enable_n: 1'b1, default: '0};
      beat_s1_r <= '0;
      beat_r <= '0;
      cke_s1_r <= 1'b0;
      cke_r <= 1'b0;
    end
    else
    begin
      pins_s1_r <= cmd_pins;
      pins_r <= pins_s1_r;
      beat_s1_r <= beat_pins;
      beat_r <= beat_s1_r;
      cke_s1_r <= clock_enable;
      cke_r <= cke_s1_r;
    end
  end

  // command receivers are only alive in the powered state
  assign rx_cmd_enable = pwr_r == PWR_ON;
  // clock and termination receivers survive power-down but not self refresh
  assign rx_clk_term_enable = pwr_r != PWR_SREF;

  assign kind = ddrpc_cmd_e'({pins_r.row_strobe_n, pins_r.col_strobe_n,
                              pins_r.write_enable_n});
  assign cmd_live = rx_cmd_enable && !pins_r.chip_select_n;
  // reads and writes are taken only while clock enable is high
  assign cmd_accept = cmd_live && cke_r;

  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_ON:
      begin
        if (!cke_r)
        begin
          if (cmd_live && kind == CMD_REF && open_r == '0)
            pwr_nxt = PWR_SREF;
          else if (open_r != '0)
            pwr_nxt = PWR_PD_ACT;
          else
            pwr_nxt = PWR_PD_PRE;
        end
      end
      PWR_PD_PRE, PWR_PD_ACT:
      begin
        if (cke_r)
          pwr_nxt = PWR_ON;
      end
      PWR_SREF:
      begin
        // no command is needed to leave; clock enable alone brings it back
        if (cke_r)
          pwr_nxt = PWR_ON;
      end
      default:
        pwr_nxt = PWR_ON;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pwr_r <= PWR_PD_PRE;
    else
      pwr_r <= pwr_nxt;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_regs_r[SEL_MR] <= MR_RESET;
      mode_regs_r[SEL_EMR1] <= EMR_RESET;
      mode_regs_r[2] <= EMR_RESET;
      mode_regs_r[3] <= EMR_RESET;
    end
    else if (cmd_accept && kind == CMD_MRS)
      // bank_select picks the target, address_inputs carry the opcode
      mode_regs_r[pins_r.bank_select[1:0]] <= pins_r.address_inputs;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      open_r <= '0;
    else if (cmd_accept)
    begin
      case (kind)
        CMD_ACT:
          open_r[pins_r.bank_select] <= 1'b1;
        CMD_PRE:
        begin
          if (pins_r.address_inputs[AP_BIT])
            open_r <= '0;
          else
            open_r[pins_r.bank_select] <= 1'b0;
        end
        CMD_RD, CMD_WR:
        begin
          if (pins_r.address_inputs[AP_BIT])
            open_r[pins_r.bank_select] <= 1'b0;
        end
        default:
          open_r <= open_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_r <= '{kind: CMD_NOP, default: '0};
    else
    begin
      cmd_r.valid <= cmd_accept && kind != CMD_NOP;
      cmd_r.kind <= cmd_accept ? kind : CMD_NOP;
      cmd_r.bank <= pins_r.bank_select;
      cmd_r.row <= pins_r.address_inputs;
      cmd_r.col <= pins_r.address_inputs[COL_W-1:0];
      cmd_r.auto_pre <= pins_r.address_inputs[AP_BIT] && (kind == CMD_RD || kind == CMD_WR);
      cmd_r.pre_all <= pins_r.address_inputs[AP_BIT] && kind == CMD_PRE;
    end
  end

  // accesses attempted in the cycle clock enable drops, while still powered, are flagged, not performed
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      access_cke_low <= 1'b0;
    else
      access_cke_low <= cmd_live && !cke_r && (kind == CMD_RD || kind == CMD_WR);
  end

  // write burst: one beat per strobe edge, addressed as it enters the fifo
  assign fifo_in_valid = wr_act_r && beat_r.valid;
  assign fifo_in.addr = mem_addr(wr_bank_r, wr_col_r);
  // with the pin serving as read strobe there is no mask to honour
  assign fifo_in.mask = beat_r.mask && !read_only_strobe_sel;
  assign fifo_in.data = beat_r.data;
  assign beat_ready = fifo_in_ready;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_act_r <= 1'b0;
      wr_bank_r <= '0;
      wr_col_r <= '0;
      beats_left_r <= '0;
    end
    else if (cmd_accept && kind == CMD_WR)
    begin
      wr_act_r <= 1'b1;
      wr_bank_r <= pins_r.bank_select;
      wr_col_r <= pins_r.address_inputs[COL_W-1:0];
      beats_left_r <= burst_beats(mode_regs_r[SEL_MR]);
    end
    else if (fifo_in_valid && fifo_in_ready)
    begin
      wr_col_r <= wr_col_r + 1'b1;
      beats_left_r <= beats_left_r - 1'b1;
      if (beats_left_r == 4'h1)
        wr_act_r <= 1'b0;
    end
  end

  ddrpc_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_beat_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // reads own the array port; queued write beats wait behind them
  assign rd_fire = cmd_accept && kind == CMD_RD;
  assign fifo_out_ready = !rd_fire;

  ddrpc_mem #(
    .AW(MEM_AW),
    .DW(DATA_W)
  ) u_store (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(fifo_out_valid && fifo_out_ready && !fifo_out.mask),
    .wr_addr(fifo_out.addr),
    .wr_data(fifo_out.data),
    .rd_en(rd_fire),
    .rd_addr(mem_addr(pins_r.bank_select, pins_r.address_inputs[COL_W-1:0])),
    .rd_data(read_data)
  );

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rd_pend_r <= 1'b0;
    else
      rd_pend_r <= rd_fire;
  end

  // termination: either rtt bit set in the extended register enables it
  assign term_allowed = mode_regs_r[SEL_EMR1][EMR_RTT_LO_BIT]
                      | mode_regs_r[SEL_EMR1][EMR_RTT_HI_BIT];
  assign term_on = term_allowed && rx_clk_term_enable
                && pins_r.termination_control;
  assign read_only_strobe_sel = org_x8 && mode_regs_r[SEL_EMR1][EMR_READ_ONLY_STROBE_BIT];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      term_data_enable <= 1'b0;
      term_upper_enable <= 1'b0;
      term_mask_enable <= 1'b0;
    end
    else
    begin
      // data, lower strobe pair and the read strobe pair
      term_data_enable <= term_on;
      // mask pin is terminated in both its roles
      term_mask_enable <= term_on;
      term_upper_enable <= term_on && org_x16;
    end
  end

  assign power_state = pwr_r;
  assign bank_open = open_r;
  assign cmd_out = cmd_r;
  assign mode_reg = mode_regs_r[SEL_MR];
  assign ext_mode_reg = mode_regs_r[SEL_EMR1];
  assign mask_pin_is_read_strobe = read_only_strobe_sel;
  assign write_active = wr_act_r;
  assign read_valid = rd_pend_r;
endmodule : ddrpc_top
